// ---- hdl/hcas_top.sv ----
// Channel activation sequencer for one tx and one rx channel direction.
// Walks the descriptor list in shared memory over a simple memory master
// port (bus master side of the host bridge), moves data to/from the serial
// port one word per buffer step, and writes status and acknowledge records.
// Assumes the memory port answers each request with a one-cycle done pulse.
//
// Implementation choices: the address map and the AHB-Lite register port.
`default_nettype none
module hcas_top
  import hcas_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // AHB-Lite register slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic IRQ_O,
  // Shared memory master port
  output hcas_mreq_s MREQ_O,
  input wire hcas_mrsp_s MRSP_I,
  // Serial port
  input wire logic TX_SERIAL_CLOCK_I,
  input wire logic TX_FRAME_SYNC_I,
  output logic TX_SERIAL_DATA_O,
  input wire logic RX_SERIAL_CLOCK_I,
  input wire logic RX_FRAME_SYNC_I,
  input wire logic RX_SERIAL_DATA_I,
  input wire logic RX_OUT_OF_FRAME_I
);
  typedef enum {
    S_IDLE, S_HEAD, S_DESC, S_OWN, S_SLOT, S_DATA, S_SHIFT, S_STAT, S_INTR, S_NEXT, S_ACK
  } hcas_state_e;

  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_addr;
  logic [31:0] ctrl_reg;
  logic [31:0] txhead_reg;
  logic [31:0] rxhead_reg;
  logic [31:0] slot_reg;
  logic [HCAS_EV_W-1:0] irq_reg;
  logic [HCAS_EV_W-1:0] mask_reg;
  logic [HCAS_EV_W-1:0] ev_set;
  hcas_state_e state_reg;
  logic dir_rx_reg;
  logic ack_pend_reg;
  logic [31:0] desc_addr_reg;
  logic [31:0] bd_reg;
  logic [31:0] buf_ptr_reg;
  logic [HCAS_BD_LEN_W-1:0] left_reg;
  logic [31:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  hcas_mreq_s mreq_reg;
  logic map_we;
  logic [2:0] map_waddr;
  logic [31:0] map_rdata;
  logic [2:0] tx_serial_clock_s;
  logic [2:0] rclk_s;
  logic [1:0] rx_serial_data_s;
  logic [1:0] rx_frame_sync_s;
  logic [1:0] rx_out_of_frame_s;
  logic tx_serial_clock_rise;
  logic rclk_rise;
  logic act_tx;
  logic act_rx;
  logic owned;
  logic inhibit;
  logic [31:0] rd_val;

  hcas_ahb_slave u_slave (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .hsel_i(HSEL_I),
    .haddr_i(HADDR_I),
    .htrans_i(HTRANS_I),
    .hwrite_i(HWRITE_I),
    .hready_i(HREADY_I),
    .wr_o(bus_wr),
    .rd_o(bus_rd),
    .addr_o(bus_addr)
  );

  hcas_chan_map #(.DEPTH(8), .AW(3)) u_map (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .we_i(map_we),
    .waddr_i(map_waddr),
    .wdata_i(MRSP_I.rdata),
    .raddr_i({dir_rx_reg, 2'h0}),
    .rdata_o(map_rdata)
  );

  // Ownership sense differs per direction
  function automatic logic own_of(input logic rx, input logic [31:0] bd);
    own_of = rx ? !bd[HCAS_BD_OWNER] : bd[HCAS_BD_OWNER];
  endfunction

  assign owned = own_of(dir_rx_reg, bd_reg);
  assign inhibit = dir_rx_reg ? ctrl_reg[HCAS_CTRL_RXINH] : ctrl_reg[HCAS_CTRL_TXINH];
  assign act_tx = bus_wr && bus_addr == HCAS_CTRL_OFS && HWDATA_I[HCAS_CTRL_TXACT];
  assign act_rx = bus_wr && bus_addr == HCAS_CTRL_OFS && HWDATA_I[HCAS_CTRL_RXACT];

  // Map slots: 0 head, 1 descriptor per direction (dir in bit 2)
  assign map_we = MRSP_I.done && (state_reg == S_HEAD || state_reg == S_DESC);
  assign map_waddr = {dir_rx_reg, 1'b0, state_reg == S_DESC};

  // Serial input synchronisers
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      tx_serial_clock_s <= 3'h0;
      rclk_s <= 3'h0;
      rx_serial_data_s <= 2'h0;
      rx_frame_sync_s <= 2'h0;
      rx_out_of_frame_s <= 2'h0;
    end
    else
    begin
      tx_serial_clock_s <= {tx_serial_clock_s[1:0], TX_SERIAL_CLOCK_I};
      rclk_s <= {rclk_s[1:0], RX_SERIAL_CLOCK_I};
      rx_serial_data_s <= {rx_serial_data_s[0], RX_SERIAL_DATA_I};
      rx_frame_sync_s <= {rx_frame_sync_s[0], RX_FRAME_SYNC_I};
      rx_out_of_frame_s <= {rx_out_of_frame_s[0], RX_OUT_OF_FRAME_I};
    end
  end

  assign tx_serial_clock_rise = tx_serial_clock_s[1] && !tx_serial_clock_s[2];
  assign rclk_rise = rclk_s[1] && !rclk_s[2];

  // Control, head pointer and interrupt mask registers
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_reg <= HCAS_CTRL_RST;
      txhead_reg <= 32'h0000_0000;
      rxhead_reg <= 32'h0000_0000;
      mask_reg <= HCAS_MASK_RST;
    end
    else if (bus_wr)
    begin
      case (bus_addr)
        HCAS_CTRL_OFS: ctrl_reg <= {27'h0, HWDATA_I[4:2], 2'h0};
        HCAS_TXHEAD_OFS: txhead_reg <= HWDATA_I;
        HCAS_RXHEAD_OFS: rxhead_reg <= HWDATA_I;
        HCAS_MASK_OFS: mask_reg <= HWDATA_I[HCAS_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  assign ev_set[HCAS_EV_SERVICE_ACK_DESCRIPTOR] = state_reg == S_ACK && MRSP_I.done;
  assign ev_set[HCAS_EV_EOM] = state_reg == S_STAT
    && (mreq_reg.valid ? MRSP_I.done : inhibit);
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      irq_reg <= '0;
    else if (bus_wr && bus_addr == HCAS_IRQ_OFS)
      irq_reg <= (irq_reg & ~HWDATA_I[HCAS_EV_W-1:0]) | ev_set;
    else
      irq_reg <= irq_reg | ev_set;
  end
  assign IRQ_O = |(irq_reg & mask_reg);

  // Read mux, combinational from the latched address in the data phase
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (bus_addr)
      HCAS_CTRL_OFS: rd_val = ctrl_reg;
      HCAS_TXHEAD_OFS: rd_val = txhead_reg;
      HCAS_RXHEAD_OFS: rd_val = rxhead_reg;
      HCAS_STAT_OFS: rd_val = {24'h0, dir_rx_reg, ack_pend_reg, 2'h0, 4'(state_reg)};
      HCAS_IRQ_OFS: rd_val = {30'h0, irq_reg};
      HCAS_MASK_OFS: rd_val = {30'h0, mask_reg};
      HCAS_SLOT_OFS: rd_val = slot_reg;
      default: rd_val = 32'h0000_0000;
    endcase
  end
  assign HRDATA_O = bus_rd ? rd_val : 32'h0000_0000;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  // List walking sequencer
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= S_IDLE;
      dir_rx_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      desc_addr_reg <= 32'h0000_0000;
      bd_reg <= 32'h0000_0000;
      buf_ptr_reg <= 32'h0000_0000;
      left_reg <= '0;
      slot_reg <= 32'h0000_0000;
      shift_reg <= 32'h0000_0000;
      bit_cnt_reg <= 5'h00;
      mreq_reg <= '0;
    end
    else if (act_tx || act_rx)
    begin
      // Activation restarts the walk at the head pointer
      dir_rx_reg <= act_rx && !act_tx;
      ack_pend_reg <= 1'b1;
      mreq_reg <= '{1'b1, 1'b0, act_tx ? txhead_reg : rxhead_reg, 32'h0};
      state_reg <= S_HEAD;
    end
    else
    begin
      case (state_reg)
        S_IDLE: mreq_reg.valid <= 1'b0;
        S_HEAD:
          if (MRSP_I.done)
          begin
            desc_addr_reg <= MRSP_I.rdata;
            mreq_reg <= '{1'b1, 1'b0, MRSP_I.rdata, 32'h0};
            state_reg <= S_DESC;
          end
        S_DESC:
          if (MRSP_I.done)
          begin
            bd_reg <= MRSP_I.rdata;
            mreq_reg.valid <= 1'b0;
            state_reg <= ack_pend_reg ? S_ACK : S_OWN;
          end
        S_ACK:
          if (!mreq_reg.valid)
            mreq_reg <= '{1'b1, 1'b1, slot_reg, {31'h0, dir_rx_reg}};
          else if (MRSP_I.done)
          begin
            ack_pend_reg <= 1'b0;
            mreq_reg.valid <= 1'b0;
            state_reg <= S_OWN;
          end
        S_OWN:
          if (owned)
          begin
            buf_ptr_reg <= desc_addr_reg + HCAS_MD_DATA_OFS;
            left_reg <= bd_reg[HCAS_BD_LEN_W-1:0];
            state_reg <= S_SLOT;
          end
          else if (ctrl_reg[HCAS_CTRL_POLL])
          begin
            mreq_reg <= '{1'b1, 1'b0, desc_addr_reg, 32'h0};
            state_reg <= S_DESC;
          end
        S_SLOT:
        begin
          // Inhibit 0 keeps descriptor address, 1 prefetches next pointer
          slot_reg <= inhibit ? desc_addr_reg + HCAS_MD_NEXT_OFS : desc_addr_reg;
          // Only tx fetches here; rx writes once a whole word is gathered
          mreq_reg <= '{!dir_rx_reg, 1'b0, buf_ptr_reg, 32'h0};
          bit_cnt_reg <= 5'h00;
          state_reg <= dir_rx_reg ? S_SHIFT : S_DATA;
        end
        S_DATA:
          if (MRSP_I.done)
          begin
            mreq_reg.valid <= 1'b0;
            if (!dir_rx_reg)
              shift_reg <= MRSP_I.rdata;
            bit_cnt_reg <= 5'h00;
            // Tx always shifts the fetched word out; rx ends after its last write
            state_reg <= (dir_rx_reg && left_reg <= 14'h4) ? S_STAT : S_SHIFT;
            left_reg <= (left_reg <= 14'h4) ? '0 : left_reg - 14'h4;
            buf_ptr_reg <= buf_ptr_reg + 32'h0000_0004;
          end
        S_SHIFT:
          if ((dir_rx_reg ? rclk_rise && rx_frame_sync_s[1] && !rx_out_of_frame_s[1] : tx_serial_clock_rise))
          begin
            if (dir_rx_reg)
              shift_reg <= {shift_reg[30:0], rx_serial_data_s[1]};
            else
              shift_reg <= {shift_reg[30:0], 1'b1};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'h1F)
            begin
              if (!dir_rx_reg && left_reg == '0)
                state_reg <= S_STAT;
              else
              begin
                mreq_reg <= '{1'b1, dir_rx_reg, buf_ptr_reg, {shift_reg[30:0], rx_serial_data_s[1]}};
                state_reg <= S_DATA;
              end
            end
          end
        S_STAT:
          if (!mreq_reg.valid)
          begin
            if (inhibit)
              state_reg <= S_INTR;
            else
              mreq_reg <= '{1'b1, 1'b1, desc_addr_reg, {1'b0, bd_reg[30:0]}};
          end
          else if (MRSP_I.done)
          begin
            mreq_reg.valid <= 1'b0;
            state_reg <= S_INTR;
          end
        S_INTR:
        begin
          // Interrupt descriptor only when the buffer asks for it
          if (!mreq_reg.valid && bd_reg[HCAS_BD_EOBI])
            mreq_reg <= '{1'b1, 1'b1, slot_reg, 32'h0000_0002};
          else if (!mreq_reg.valid || MRSP_I.done)
          begin
            mreq_reg <= '{1'b1, 1'b0, inhibit ? slot_reg : desc_addr_reg + HCAS_MD_NEXT_OFS,
                          32'h0};
            state_reg <= S_NEXT;
          end
        end
        S_NEXT:
          if (MRSP_I.done)
          begin
            desc_addr_reg <= MRSP_I.rdata;
            mreq_reg <= '{1'b1, 1'b0, MRSP_I.rdata, 32'h0};
            state_reg <= S_DESC;
          end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign MREQ_O = mreq_reg;
  assign TX_SERIAL_DATA_O = shift_reg[31];

  // Head pointer fetched before descriptor after activation
  a_head_first: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (act_tx || act_rx) |=> state_reg == S_HEAD) else $error("head not first");
  a_map_head: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (state_reg == S_HEAD && MRSP_I.done && !act_tx && !act_rx) |=> state_reg == S_DESC)
    else $error("descriptor not after head");
  a_ack_event: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (state_reg == S_ACK && MRSP_I.done) |=> irq_reg[HCAS_EV_SERVICE_ACK_DESCRIPTOR]) else $error("ack lost");
  a_tx_owner: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (state_reg == S_OWN && !dir_rx_reg && !bd_reg[HCAS_BD_OWNER] && !act_tx && !act_rx
     && !ctrl_reg[HCAS_CTRL_POLL]) |=> state_reg == S_OWN) else $error("tx not owned");
  a_rx_owner: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (state_reg == S_OWN && dir_rx_reg && !bd_reg[HCAS_BD_OWNER] && !act_tx && !act_rx)
    |=> state_reg == S_SLOT) else $error("rx owned not taken");
  a_slot_keep: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (state_reg == S_SLOT && !inhibit && !act_tx && !act_rx) |=> slot_reg == $past(desc_addr_reg))
    else $error("slot wrong");
  a_slot_next: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (state_reg == S_SLOT && inhibit && !act_tx && !act_rx)
    |=> slot_reg == $past(desc_addr_reg) + HCAS_MD_NEXT_OFS) else $error("prefetch wrong");
  a_eom_event: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (state_reg == S_STAT && MRSP_I.done) |=> irq_reg[HCAS_EV_EOM]) else $error("eom lost");
  a_loop_back: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (state_reg == S_NEXT && MRSP_I.done && !act_tx && !act_rx) |=> state_reg == S_DESC)
    else $error("list not followed");
endmodule
`default_nettype wire

// ---- hdl/hcas_pkg.sv ----
// Package for the channel activation sequencer: register map, field layout,
// descriptor bit positions, reset values and shared types.
// Assumes a single 10 MHz clock domain and an AHB-Lite register slave.
`default_nettype none
package hcas_pkg;
  // Register byte offsets
  localparam logic [7:0] HCAS_CTRL_OFS = 8'h00;
  localparam logic [7:0] HCAS_TXHEAD_OFS = 8'h04;
  localparam logic [7:0] HCAS_RXHEAD_OFS = 8'h08;
  localparam logic [7:0] HCAS_STAT_OFS = 8'h0C;
  localparam logic [7:0] HCAS_IRQ_OFS = 8'h10;
  localparam logic [7:0] HCAS_MASK_OFS = 8'h14;
  localparam logic [7:0] HCAS_SLOT_OFS = 8'h18;
  // Control register bits
  localparam int HCAS_CTRL_TXACT = 0;
  localparam int HCAS_CTRL_RXACT = 1;
  localparam int HCAS_CTRL_TXINH = 2;
  localparam int HCAS_CTRL_RXINH = 3;
  localparam int HCAS_CTRL_POLL = 4;
  // Buffer descriptor fields
  localparam int HCAS_BD_OWNER = 31;
  localparam int HCAS_BD_EOBI = 29;
  localparam int HCAS_BD_LEN_W = 14;
  // Interrupt event bits
  localparam int HCAS_EV_SERVICE_ACK_DESCRIPTOR = 0;
  localparam int HCAS_EV_EOM = 1;
  localparam int HCAS_EV_W = 2;
  // Reset values
  localparam logic [31:0] HCAS_CTRL_RST = 32'h0000_0000;
  localparam logic [HCAS_EV_W-1:0] HCAS_MASK_RST = 2'h0;
  // Descriptor word offsets within a message descriptor
  localparam logic [31:0] HCAS_MD_DATA_OFS = 32'h0000_0004;
  localparam logic [31:0] HCAS_MD_NEXT_OFS = 32'h0000_0008;
  // Memory master request and response
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hcas_mreq_s;
  typedef struct packed {
    logic done;
    logic [31:0] rdata;
  } hcas_mrsp_s;
endpackage
`default_nettype wire

// ---- hdl/hcas_ahb_slave.sv ----
// AHB-Lite slave front end: latches the address phase and presents a
// one-cycle register access strobe in the data phase. Zero wait states.
// Assumes single word transfers; response always OKAY.
`default_nettype none
module hcas_ahb_slave
  import hcas_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o
);
  logic wr_reg;
  logic rd_reg;
  logic [7:0] addr_reg;
  logic take;

  // Accept NONSEQ or SEQ when the bus is ready
  assign take = hsel_i && htrans_i[1] && hready_i;

  // Latch address phase for the following data phase
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else
    begin
      wr_reg <= take && hwrite_i;
      rd_reg <= take && !hwrite_i;
      if (take)
        addr_reg <= haddr_i[7:0];
    end
  end

  assign wr_o = wr_reg;
  assign rd_o = rd_reg;
  assign addr_o = addr_reg;
endmodule
`default_nettype wire

// ---- hdl/hcas_chan_map.sv ----
// Internal channel descriptor map: small register memory holding head
// pointer and descriptor per direction.
// Read data leave a register one cycle after the address.
`default_nettype none
module hcas_chan_map
  import hcas_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = 3
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem_reg [DEPTH];
  logic [31:0] rdata_reg;

  // Write port and registered read port
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= 32'h0000_0000;
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= 32'h0000_0000;
    end
    else
    begin
      if (we_i)
        mem_reg[waddr_i] <= wdata_i;
      rdata_reg <= mem_reg[raddr_i];
    end
  end

  assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

// ---- test/hcas_mem_model.sv ----
// Shared memory model on the far side of the sequencer's memory master port.
// Assumes one request at a time, each answered by a one-cycle done pulse.
`default_nettype none
module hcas_mem_model
  import hcas_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire hcas_mreq_s mreq_i,
  output hcas_mrsp_s mrsp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [31:0]];
  logic [1:0] wait_reg;
  // Host preload of head pointers and lists before any request
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    mem[a] = d;
  endtask
  // Answer promptly or after three idle cycles; read data toggle between answers
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mrsp_o <= '0;
      wait_reg <= 2'h0;
    end
    else if (mrsp_o.done || !mreq_i.valid)
    begin
      mrsp_o.done <= 1'b0;
      mrsp_o.rdata <= ~mrsp_o.rdata;
      wait_reg <= 2'h0;
    end
    else if (slow_i && wait_reg != 2'h3)
      wait_reg <= wait_reg + 2'h1;
    else
    begin
      mrsp_o.done <= 1'b1;
      if (mreq_i.write)
        mem[mreq_i.addr] = mreq_i.wdata;
      mrsp_o.rdata <= mem.exists(mreq_i.addr) ? mem[mreq_i.addr] : 32'h0;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the channel activation sequencer: AHB-Lite master,
// shared memory model and serial line stimulus.
// Assumes one 10 MHz clock and a memory model that answers every request.
`default_nettype none
module tb_top;
  import hcas_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, hsel, hwrite, slow, ser_clk, ser_run, rx_dat;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, sdiv;
  logic [2:0] hsize;
  logic hready, hresp, irq, tx_dat;
  hcas_mreq_s mreq;
  hcas_mrsp_s mrsp;
  int err_total, total_checks, cyc;
  logic [31:0] log_a[$];
  logic [31:0] log_d[$];
  logic log_w[$];

  hcas_top dut_u (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .IRQ_O(irq), .MREQ_O(mreq), .MRSP_I(mrsp), .TX_SERIAL_CLOCK_I(ser_clk),
    .TX_FRAME_SYNC_I(1'b1), .TX_SERIAL_DATA_O(tx_dat), .RX_SERIAL_CLOCK_I(ser_clk),
    .RX_FRAME_SYNC_I(1'b1), .RX_SERIAL_DATA_I(rx_dat), .RX_OUT_OF_FRAME_I(1'b0)
  );
  hcas_mem_model mem_u (
    .clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .mreq_i(mreq), .mrsp_o(mrsp)
  );

  // System clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Serial clock at a quarter rate, still while not running; log memory accesses
  always @(posedge clk)
  begin
    sdiv <= sdiv + 2'h1;
    ser_clk <= ser_run & sdiv[1];
    if (mrsp.done === 1'b1)
    begin
      log_a.push_back(mreq.addr);
      log_w.push_back(mreq.write);
      log_d.push_back(mreq.wdata);
    end
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One single-word AHB-Lite transfer, held until hready at each phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  function automatic int seen(input logic [31:0] a, input logic w);
    foreach (log_a[i])
      if (log_a[i] === a && log_w[i] === w)
        return i;
    return -1;
  endfunction
  task automatic wait_acc(input logic [31:0] a, input logic w);
    int n;
    n = 0;
    while (seen(a, w) < 0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // Build one list: head, descriptor, one data word, next descriptor
  task automatic list(input logic [31:0] h, d, bd, nx, nbd);
    log_a.delete();
    log_w.delete();
    log_d.delete();
    mem_u.put(h, d);
    mem_u.put(d, bd);
    mem_u.put(d + 32'h4, 32'h5A5A_C3C3);
    mem_u.put(d + 32'h8, nx);
    mem_u.put(nx, nbd);
  endtask

  task automatic t_reset();
    ahb(1'b0, HCAS_CTRL_OFS, 32'h0);
    chk_word("ctrl", HCAS_CTRL_RST, q);
    ahb(1'b0, HCAS_MASK_OFS, 32'h0);
    chk_word("mask", {30'h0, HCAS_MASK_RST}, q);
    ahb(1'b0, HCAS_IRQ_OFS, 32'h0);
    chk_word("irq status", 32'h0, q);
    ahb(1'b0, 8'h1C, 32'h0);
    chk_word("unmapped", 32'h0, q);
    chk_word("irq pin", 32'h0, {31'h0, irq});
    chk_word("resp", 32'h0, {31'h0, hresp});
  endtask
  task automatic t_tx_basic();
    list(32'h100, 32'h200, 32'hA000_0004, 32'h300, 32'h0000_0004);
    ahb(1'b1, HCAS_TXHEAD_OFS, 32'h100);
    ahb(1'b1, HCAS_CTRL_OFS, 32'h1);
    wait_acc(32'h200, 1'b1);
    chk_word("head read first", 32'h0, seen(32'h100, 1'b0));
    chk_word("desc read second", 32'h1, seen(32'h200, 1'b0));
    chk_word("data read", 32'h1, seen(32'h204, 1'b0) > 1);
    chk_word("status after data", 32'h1,
             seen(32'h200, 1'b1) > seen(32'h204, 1'b0));
    wait_acc(32'h300, 1'b0);
    chk_word("next desc read", 32'h1, seen(32'h300, 1'b0) > 0);
    chk_word("tx line idle", 32'h1, {31'h0, tx_dat});
    ahb(1'b0, HCAS_IRQ_OFS, 32'h0);
    chk_word("ack and eom", 32'h3, q);
    chk_word("masked pin", 32'h0, {31'h0, irq});
    ahb(1'b1, HCAS_MASK_OFS, 32'h2);
    @(posedge clk);
    chk_word("unmasked pin", 32'h1, {31'h0, irq});
    ahb(1'b1, HCAS_IRQ_OFS, 32'h3);
    @(posedge clk);
    chk_word("cleared pin", 32'h0, {31'h0, irq});
    ahb(1'b0, HCAS_IRQ_OFS, 32'h0);
    chk_word("cleared status", 32'h0, q);
  endtask
  task automatic t_tx_inhibit();
    int n;
    slow <= 1'b1;
    list(32'h400, 32'h500, 32'hA000_0004, 32'h600, 32'h0000_0004);
    ahb(1'b1, HCAS_TXHEAD_OFS, 32'h400);
    ahb(1'b1, HCAS_CTRL_OFS, 32'h5);
    n = 0;
    q = 32'h0;
    while (q[HCAS_EV_EOM] !== 1'b1 && n < 500)
    begin
      ahb(1'b0, HCAS_IRQ_OFS, 32'h0);
      n++;
    end
    chk_word("eom seen", 32'h1, {31'h0, q[HCAS_EV_EOM]});
    chk_word("head first", 32'h0, seen(32'h400, 1'b0));
    chk_word("no overwrite", 32'hFFFF_FFFF, seen(32'h500, 1'b1));
    ahb(1'b1, HCAS_IRQ_OFS, 32'h3);
    slow <= 1'b0;
  endtask
  task automatic t_tx_not_owned();
    list(32'h700, 32'h800, 32'h2000_0004, 32'h900, 32'h0000_0004);
    ahb(1'b1, HCAS_TXHEAD_OFS, 32'h700);
    ahb(1'b1, HCAS_CTRL_OFS, 32'h1);
    wait_acc(32'h800, 1'b0);
    repeat (100) @(posedge clk);
    chk_word("no data fetch", 32'hFFFF_FFFF, seen(32'h804, 1'b0));
    ahb(1'b0, HCAS_IRQ_OFS, 32'h0);
    chk_word("ack only", 32'h1, q);
    ahb(1'b1, HCAS_IRQ_OFS, 32'h3);
  endtask
  task automatic t_rx(input logic [31:0] bd, input logic own);
    rx_dat <= 1'b0;
    list(32'hA00, 32'hB00, bd, 32'hC00, 32'h8000_0004);
    ahb(1'b1, HCAS_RXHEAD_OFS, 32'hA00);
    ahb(1'b1, HCAS_CTRL_OFS, 32'h2);
    wait_acc(32'hB00, 1'b0);
    chk_word("rx head first", 32'h0, seen(32'hA00, 1'b0));
    chk_word("rx desc second", 32'h1, seen(32'hB00, 1'b0));
    wait_acc(32'hC00, 1'b0);
    if (own)
    begin
      chk_word("rx data", 32'h0, log_d[seen(32'hB04, 1'b1)]);
      chk_word("rx status after data", 32'h1,
               seen(32'hB00, 1'b1) > seen(32'hB04, 1'b1));
      chk_word("rx next desc", 32'h1, seen(32'hC00, 1'b0) > 0);
    end
    else
      chk_word("rx not owned", 32'hFFFF_FFFF, seen(32'hB04, 1'b1));
    ahb(1'b1, HCAS_IRQ_OFS, 32'h3);
  endtask

  // Reset, then each scenario in turn
  initial
  begin
    {hsel, hwrite, slow, ser_clk, ser_run, htrans, sdiv} = '0;
    {haddr, hwdata, q} = '0;
    hsize = 3'h2;
    rx_dat = 1'b1;
    rst_n = 1'b0;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    ser_run <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tx_basic();
    t_tx_inhibit();
    t_tx_not_owned();
    t_rx(32'h2000_0004, 1'b1);
    t_rx(32'hA000_0004, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
